//--- logic/base_field.sv
// Holds the writable part of the user flash base register.
// Assumes a write strobe already decoded and qualified by the bus slave.
`timescale 1ns/10ps
`default_nettype none
module base_field (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] wdata,
    output logic [31:0] value
);
    logic [mem_part_pkg::BASE_W-1:0] base_q;
    logic [mem_part_pkg::BASE_W-1:0] base_d;

    // Bits 19:16 sit in lane 2, bits 15:11 in lane 1
    assign base_d = {byteenable[2] ? wdata[19:16] : base_q[8:5],
                     byteenable[1] ? wdata[15:11] : base_q[4:0]};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            base_q <= mem_part_pkg::BASE_RESET;
        end else if (wr_en) begin
            base_q <= base_d;
        end
    end

    // Upper bits and low eleven bits read as zero
    assign value = {12'h000, base_q, 11'h000};

    a_base_write: assert property (@(posedge clk) disable iff (!rst_b)
        wr_en && byteenable[2] |=> base_q[8:5] == $past(wdata[19:16]))
        else $error("base field did not take written value");
    a_base_lowzero: assert property (@(posedge clk) disable iff (!rst_b)
        value[10:0] == 11'h000 && value[31:20] == 12'h000)
        else $error("fixed bits of base register not zero");
endmodule
`default_nettype wire

//--- logic/mem_part_pkg.sv
// Package for the memory partition register bank.
// Assumes a 32-bit Avalon-MM slave with word addressing by byte offset.
package mem_part_pkg;

    // Byte offsets of the registers
    localparam logic [3:0] DATA_RAM_SIZE_OFF = 4'h0;
    localparam logic [3:0] USER_FLASH_BASE_OFF = 4'h4;
    localparam logic [3:0] FLASH_SIZE_OFF = 4'h8;
    localparam logic [3:0] BOUND_STATUS_OFF = 4'hC;

    // Legal data RAM sizes in bytes
    localparam logic [31:0] RAM_8K = 32'h0000_2000;
    localparam logic [31:0] RAM_16K = 32'h0000_4000;
    localparam logic [31:0] RAM_32K = 32'h0000_8000;
    localparam logic [31:0] RAM_64K = 32'h0001_0000;

    // User flash base field layout
    localparam int BASE_LSB = 11;
    localparam int BASE_MSB = 19;
    localparam int BASE_W = 9;
    localparam logic [8:0] BASE_RESET = 9'h000;

    // Default flash size for the bounds flag
    localparam logic [31:0] FLASH_SIZE_DEFAULT = 32'h0008_0000;

    // Read answers one cycle after the request is seen
    localparam int READ_WAIT = 1;

    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } bus_req_type;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } bus_rsp_type;

endpackage

//--- logic/memory_partition_regs.sv
// Memory partition register bank behind an Avalon-MM slave.
// Assumes one synchronous master on REF_CLK, 32-bit data, byte offsets.
//
// Notes on behaviour
// - Data RAM size register is a fixed read-only byte count of legal size.
// - Bits 19:11 of user flash base are readable and writable.
// - Bits 10:0 of user flash base read zero; 2 KB step.
// - Reset clears user flash base to zero, all memory kernel mode.
// - Bits 31:20 of user flash base read zero, writes ignored.
`timescale 1ns/10ps
`default_nettype none
module memory_partition_regs #(
    parameter logic [31:0] RAM_BYTES = mem_part_pkg::RAM_64K
) (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic [31:0] USER_BASE_ADDR,
    output logic BASE_OVER_FLASH
);
    typedef enum logic [1:0] {IDLE, ANSWER, DONE} phase_type;

    mem_part_pkg::bus_req_type req;
    mem_part_pkg::bus_rsp_type rsp_q;
    mem_part_pkg::bus_rsp_type rsp_d;
    phase_type phase_q;
    phase_type phase_d;
    logic [31:0] flash_size_q;
    logic [31:0] user_base_q;
    logic over_q;
    logic [31:0] ram_size;
    logic ram_legal;
    logic [31:0] base_value;
    logic base_wr;
    logic flash_wr;
    logic [31:0] read_mux;
    logic [31:0] flash_size_d;
    logic over_d;
    logic sel_ram;
    logic sel_base;
    logic sel_flash;
    logic sel_status;
    logic take;
    logic answering;
    logic [31:0] status_word;

    assign req = '{address: AVS_ADDRESS, read: AVS_READ, write: AVS_WRITE,
                   byteenable: AVS_BYTEENABLE, writedata: AVS_WRITEDATA};

    function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
        hit = (addr == off);
    endfunction

    // Register selects from the byte offset
    assign sel_ram = hit(req.address, mem_part_pkg::DATA_RAM_SIZE_OFF);
    assign sel_base = hit(req.address, mem_part_pkg::USER_FLASH_BASE_OFF);
    assign sel_flash = hit(req.address, mem_part_pkg::FLASH_SIZE_OFF);
    assign sel_status = hit(req.address, mem_part_pkg::BOUND_STATUS_OFF);
    assign take = (phase_q == IDLE) && (req.read || req.write);
    assign answering = (phase_q == ANSWER);

    ram_size_const #(.RAM_BYTES(RAM_BYTES)) u_ram_size (
        .value(ram_size),
        .legal(ram_legal)
    );

    // Writes take effect in the cycle waitrequest drops
    assign base_wr = answering && req.write && sel_base;
    assign flash_wr = answering && req.write && sel_flash;

    base_field u_base (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .wr_en(base_wr),
        .byteenable(req.byteenable),
        .wdata(req.writedata),
        .value(base_value)
    );

    // Byte-lane merge for the flash size word
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign flash_size_d[lane*8 +: 8] = (flash_wr && req.byteenable[lane]) ?
                req.writedata[lane*8 +: 8] : flash_size_q[lane*8 +: 8];
        end
    endgenerate

    // Unmapped offsets read zero; writes there are dropped
    assign status_word = {30'h0000_0000, ram_legal, over_q};
    assign read_mux = sel_ram ? ram_size :
                      sel_base ? base_value :
                      sel_flash ? flash_size_q :
                      sel_status ? status_word : 32'h0000_0000;

    // Flags a base beyond the flash size the software must respect
    assign over_d = base_value > flash_size_q;

    always_comb begin
        phase_d = phase_q;
        rsp_d = rsp_q;
        unique case (phase_q)
            IDLE: begin
                rsp_d.waitrequest = 1'b1;
                if (take) begin
                    phase_d = ANSWER;
                    rsp_d.waitrequest = 1'b0;
                    rsp_d.readdata = req.read ? read_mux : 32'h0000_0000;
                end
            end
            ANSWER: begin
                phase_d = DONE;
                rsp_d.waitrequest = 1'b1;
            end
            DONE: begin
                phase_d = IDLE;
                rsp_d.waitrequest = 1'b1;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            phase_q <= IDLE;
            rsp_q <= '{readdata: 32'h0000_0000, waitrequest: 1'b1};
        end else begin
            phase_q <= phase_d;
            rsp_q <= rsp_d;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            flash_size_q <= mem_part_pkg::FLASH_SIZE_DEFAULT;
            user_base_q <= 32'h0000_0000;
            over_q <= 1'b0;
        end else begin
            flash_size_q <= flash_size_d;
            user_base_q <= base_value;
            over_q <= over_d;
        end
    end

    assign AVS_READDATA = rsp_q.readdata;
    assign AVS_WAITREQUEST = rsp_q.waitrequest;
    assign USER_BASE_ADDR = user_base_q;
    assign BASE_OVER_FLASH = over_q;

    // Fixed size word
    a_ram_size_fixed: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        answering && $past(req.read) && $past(sel_ram)
        |-> AVS_READDATA == RAM_BYTES)
        else $error("ram size read wrong");

    a_ram_size_legal: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        ram_legal)
        else $error("ram size not a legal value");

    a_ram_size_value: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        ram_size == RAM_BYTES)
        else $error("ram size word differs from build value");

    a_ram_write_dropped: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        answering && req.write && sel_ram
        |=> $stable(flash_size_q) && $stable(base_value))
        else $error("write to ram size changed a register");

    // Writable base field
    a_base_read: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        answering && $past(req.read) && $past(sel_base)
        |-> AVS_READDATA == $past(base_value))
        else $error("base read does not match register");

    a_base_readback: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        base_wr && req.byteenable[2:1] == 2'b11
        |=> ##1 user_base_q[19:11] == $past(req.writedata[19:11], 2))
        else $error("base write not seen on output");

    a_base_lane_keep: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        base_wr && !req.byteenable[2]
        |=> base_value[19:16] == $past(base_value[19:16]))
        else $error("disabled lane of base changed");

    a_base_lane_low: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        base_wr && req.byteenable[1]
        |=> base_value[15:11] == $past(req.writedata[15:11]))
        else $error("lane one of base not written");

    a_base_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        !base_wr
        |=> base_value == $past(base_value))
        else $error("base changed without a write");

    a_base_mirror: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        USER_BASE_ADDR == $past(base_value))
        else $error("base output does not follow register");

    // Bits that always read zero
    a_base_low_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        USER_BASE_ADDR[10:0] == 11'h000)
        else $error("base low bits not zero");

    a_base_read_low: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        answering && $past(req.read) && $past(sel_base)
        |-> AVS_READDATA[10:0] == 11'h000)
        else $error("base read low bits not zero");

    a_upper_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        USER_BASE_ADDR[31:20] == 12'h000)
        else $error("base upper bits not zero");

    a_upper_ignored: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        base_wr && req.writedata[31:20] != 12'h000
        |=> base_value[31:20] == 12'h000)
        else $error("write reached base upper bits");

    a_base_read_high: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        answering && $past(req.read) && $past(sel_base)
        |-> AVS_READDATA[31:20] == 12'h000)
        else $error("base read upper bits not zero");

    // Values held in reset
    a_reset_base_zero: assert property (@(posedge REF_CLK)
        !RST_B
        |-> USER_BASE_ADDR == 32'h0000_0000)
        else $error("base not zero in reset");

    a_reset_inner_zero: assert property (@(posedge REF_CLK)
        !RST_B
        |-> base_value == 32'h0000_0000)
        else $error("base register not zero in reset");

    a_reset_bus_idle: assert property (@(posedge REF_CLK)
        !RST_B
        |-> AVS_WAITREQUEST && AVS_READDATA == 32'h0000_0000)
        else $error("bus outputs not idle in reset");

    a_reset_flash_default: assert property (@(posedge REF_CLK)
        !RST_B
        |-> flash_size_q == mem_part_pkg::FLASH_SIZE_DEFAULT && !BASE_OVER_FLASH)
        else $error("flash size or flag wrong in reset");

    // Flash size word and bound flag
    a_over_flag: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        over_q == $past(base_value > flash_size_q))
        else $error("bound flag does not track base");

    a_flash_write: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        flash_wr && req.byteenable == 4'hF
        |=> flash_size_q == $past(req.writedata))
        else $error("flash size write lost");

    a_flash_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        !flash_wr
        |=> $stable(flash_size_q))
        else $error("flash size changed without a write");

    a_flash_read: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        answering && $past(req.read) && $past(sel_flash)
        |-> AVS_READDATA == $past(flash_size_q))
        else $error("flash size read wrong");

    a_status_read: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        answering && $past(req.read) && $past(sel_status)
        |-> AVS_READDATA == {30'h0000_0000, $past(ram_legal), $past(over_q)})
        else $error("status read wrong");

    // Bus handshake
    a_wait_release: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        phase_q == IDLE && (AVS_READ || AVS_WRITE)
        |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST [*2])
        else $error("waitrequest sequence wrong");

    a_wait_phase: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        AVS_WAITREQUEST == !answering)
        else $error("waitrequest low outside the answer cycle");

    a_phase_step: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        answering
        |=> phase_q == DONE ##1 phase_q == IDLE)
        else $error("answer not followed by the rest cycles");

    a_read_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        !take
        |=> $stable(AVS_READDATA))
        else $error("read data moved without a request");

    a_write_data_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        take && !req.read
        |=> AVS_READDATA == 32'h0000_0000)
        else $error("write answer carries read data");

    a_unmapped_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        answering && $past(req.read) &&
        !$past(sel_ram || sel_base || sel_flash || sel_status)
        |-> AVS_READDATA == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_write_window: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        base_wr || flash_wr
        |-> !AVS_WAITREQUEST)
        else $error("register written outside the answer cycle");

    // Main scenarios
    c_read_ram: cover property (@(posedge REF_CLK) disable iff (!RST_B)
        answering && req.read && sel_ram);
    c_write_base: cover property (@(posedge REF_CLK) disable iff (!RST_B)
        base_wr);
    c_write_flash: cover property (@(posedge REF_CLK) disable iff (!RST_B)
        flash_wr);
    c_read_status: cover property (@(posedge REF_CLK) disable iff (!RST_B)
        answering && req.read && sel_status);
    c_over: cover property (@(posedge REF_CLK) disable iff (!RST_B)
        $rose(over_q));
endmodule
`default_nettype wire

//--- logic/ram_size_const.sv
// Supplies the fixed data RAM size word.
// Assumes the size parameter is set to one of the legal values at build time.
`timescale 1ns/10ps
`default_nettype none
module ram_size_const #(
    parameter logic [31:0] RAM_BYTES = mem_part_pkg::RAM_64K
) (
    output logic [31:0] value,
    output logic legal
);
    assign value = RAM_BYTES;
    assign legal = (RAM_BYTES == mem_part_pkg::RAM_8K) ||
                   (RAM_BYTES == mem_part_pkg::RAM_16K) ||
                   (RAM_BYTES == mem_part_pkg::RAM_32K) ||
                   (RAM_BYTES == mem_part_pkg::RAM_64K);
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the memory partition register bank.
// Assumes the package and design files under logic/ are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [31:0] RAM_SEL = mem_part_pkg::RAM_32K;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b1;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic waitrequest;
    logic [31:0] user_base;
    logic over_flash;
    logic [31:0] rd;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    logic [3:0] be_tab [5] = '{4'hF, 4'hF, 4'hF, 4'h4, 4'h2};
    logic [31:0] wd_tab [5] = '{32'hFFFF_FFFF, 32'h0000_0800, 32'h0008_0000,
                                32'hFFFF_FFFF, 32'h0000_F800};
    logic [31:0] ex_tab [5] = '{32'h000F_F800, 32'h0000_0800, 32'h0008_0000,
                                32'h000F_0000, 32'h000F_F800};

    always #2 ref_clk = ~ref_clk;

    memory_partition_regs #(.RAM_BYTES(RAM_SEL)) i_dut (
        .REF_CLK(ref_clk),
        .RST_B(rst_b),
        .AVS_ADDRESS(address),
        .AVS_READ(read),
        .AVS_WRITE(write),
        .AVS_BYTEENABLE(byteenable),
        .AVS_WRITEDATA(writedata),
        .AVS_READDATA(readdata),
        .AVS_WAITREQUEST(waitrequest),
        .USER_BASE_ADDR(user_base),
        .BASE_OVER_FLASH(over_flash)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("mismatches %0d, compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hold the request until waitrequest is sampled low at an edge
    task automatic wait_answer;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
    endtask

    task automatic bus_write(input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
        address <= a;
        byteenable <= be;
        writedata <= d;
        write <= 1'b1;
        wait_answer();
        write <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
        address <= a;
        read <= 1'b1;
        wait_answer();
        d = readdata;
        read <= 1'b0;
        @(posedge ref_clk);
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            complete_run();
        end
    end

    initial begin
        rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check({31'h0, waitrequest}, 32'h0000_0001);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        bus_read(mem_part_pkg::USER_FLASH_BASE_OFF, rd);
        check(rd, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            bus_write(mem_part_pkg::USER_FLASH_BASE_OFF, be_tab[i], wd_tab[i]);
            #1;
            check(user_base, ex_tab[i]);
            check({31'h0, over_flash}, {31'h0, ex_tab[i] > mem_part_pkg::FLASH_SIZE_DEFAULT});
            @(posedge ref_clk);
            bus_read(mem_part_pkg::USER_FLASH_BASE_OFF, rd);
            check({21'h0, rd[10:0]}, 32'h0000_0000);
            check({20'h0, rd[31:20]}, 32'h0000_0000);
            check(rd, ex_tab[i]);
        end
        // Size word must survive a write attempt
        bus_write(mem_part_pkg::DATA_RAM_SIZE_OFF, 4'hF, 32'h0000_0000);
        bus_read(mem_part_pkg::DATA_RAM_SIZE_OFF, rd);
        check(rd, RAM_SEL);
        bus_read(mem_part_pkg::BOUND_STATUS_OFF, rd);
        check(rd, 32'h0000_0003);
        bus_read(mem_part_pkg::FLASH_SIZE_OFF, rd);
        check(rd, mem_part_pkg::FLASH_SIZE_DEFAULT);
        // Raise the flash size so the programmed base is legal again
        bus_write(mem_part_pkg::FLASH_SIZE_OFF, 4'hF, 32'h0010_0000);
        bus_read(mem_part_pkg::FLASH_SIZE_OFF, rd);
        check(rd, 32'h0010_0000);
        bus_write(mem_part_pkg::BOUND_STATUS_OFF, 4'hF, 32'h0000_0000);
        bus_read(mem_part_pkg::BOUND_STATUS_OFF, rd);
        check(rd, 32'h0000_0002);
        check(user_base, 32'h000F_F800);
        bus_read(4'h2, rd);
        check(rd, 32'h0000_0000);
        // Reset in mid-run with a nonzero base
        rst_b <= 1'b0;
        @(posedge ref_clk);
        #1;
        check(user_base, 32'h0000_0000);
        check({31'h0, over_flash}, 32'h0000_0000);
        check({31'h0, waitrequest}, 32'h0000_0001);
        check(readdata, 32'h0000_0000);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        bus_read(mem_part_pkg::USER_FLASH_BASE_OFF, rd);
        check(rd, 32'h0000_0000);
        bus_read(mem_part_pkg::FLASH_SIZE_OFF, rd);
        check(rd, mem_part_pkg::FLASH_SIZE_DEFAULT);
        complete_run();
    end
endmodule
`default_nettype wire
